// >>> rtl/cntc_channel.sv
// one channel copy of the path configuration, tuning word and load logic
`timescale 1ns/1ps
module cntc_channel (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_sel,
  input wire logic [11:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic sync_rise,
  input wire logic [15:0] test_tone_level,
  output logic [7:0] cfg_q,
  output logic [7:0] update_q,
  output logic [15:0] tw_q,
  output cntc_pkg::cntc_ctrl_s ctrl
);

  // ****************************************
  // state
  // ****************************************
  logic [7:0] cfg_ff, nxt_cfg;
  logic req_ff, nxt_req;
  logic sync_edge_ff, nxt_sync_edge;
  logic ack_ff, nxt_ack;
  logic [15:0] tw_ff, nxt_tw;
  logic [15:0] active_ff, nxt_active;
  logic [15:0] dc_ff, nxt_dc;
  logic pulse_ff, nxt_pulse;
  cntc_pkg::cntc_load_e state_ff, nxt_state;
  logic req_rise;
  logic arm_start;
  logic load_now;

  // ****************************************
  // next values
  // ****************************************
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_req = req_ff;
    nxt_sync_edge = sync_edge_ff;
    nxt_tw = tw_ff;
    nxt_state = state_ff;
    req_rise = 1'b0;
    arm_start = 1'b0;
    load_now = 1'b0;
    if (wr_sel) begin
      case (wr_addr)
        cntc_pkg::PATH_CFG_ADDR: begin
          nxt_cfg = wr_data & cntc_pkg::CFG_WRITE_MASK;
        end
        cntc_pkg::TUNING_UPDATE_ADDR: begin
          nxt_req = wr_data[cntc_pkg::UPD_REQUEST_BIT];
          nxt_sync_edge = wr_data[cntc_pkg::UPD_SYNC_EDGE_BIT];
          // a 0 to 1 step of the request bit asks for a load, and a 0 to 1 step of the sync edge bit arms one
          req_rise = nxt_req & ~req_ff;
          arm_start = nxt_sync_edge & (req_rise | ~sync_edge_ff);
        end
        cntc_pkg::TUNING_WORD_BYTE0_ADDR: begin
          nxt_tw[7:0] = wr_data;
        end
        cntc_pkg::TUNING_WORD_BYTE1_ADDR: begin
          nxt_tw[15:8] = wr_data;
        end
        default: begin
          nxt_tw = tw_ff;
        end
      endcase
    end
    case (state_ff)
      cntc_pkg::LOAD_IDLE: begin
        if (arm_start) begin
          nxt_state = cntc_pkg::LOAD_ARMED;
        end else if (req_rise) begin
          load_now = 1'b1;
        end
      end
      cntc_pkg::LOAD_ARMED: begin
        if (sync_rise) begin
          load_now = 1'b1;
          nxt_state = cntc_pkg::LOAD_IDLE;
        end else if (!nxt_sync_edge) begin
          // a request edge that also clears the sync bit loads at once
          load_now = req_rise;
          nxt_state = cntc_pkg::LOAD_IDLE;
        end
      end
      default: begin
        nxt_state = cntc_pkg::LOAD_IDLE;
      end
    endcase
    // a new request clears the flag, the load itself sets it and wins
    nxt_ack = ack_ff;
    if (arm_start || req_rise) begin
      nxt_ack = 1'b0;
    end
    if (load_now) begin
      nxt_ack = 1'b1;
    end
    // written bytes reach the oscillator only at a load event
    nxt_active = load_now ? tw_ff : active_ff;
    nxt_pulse = load_now;
    nxt_dc = cfg_ff[cntc_pkg::CFG_DC_INJECT_BIT] ? test_tone_level : 16'h0000;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_ff <= cntc_pkg::CFG_RESET;
      req_ff <= 1'b0;
      sync_edge_ff <= 1'b0;
      ack_ff <= 1'b0;
      tw_ff <= cntc_pkg::TW_RESET;
      active_ff <= cntc_pkg::TW_RESET;
      dc_ff <= 16'h0000;
      pulse_ff <= 1'b0;
      state_ff <= cntc_pkg::LOAD_IDLE;
    end else begin
      cfg_ff <= nxt_cfg;
      req_ff <= nxt_req;
      sync_edge_ff <= nxt_sync_edge;
      ack_ff <= nxt_ack;
      tw_ff <= nxt_tw;
      active_ff <= nxt_active;
      dc_ff <= nxt_dc;
      pulse_ff <= nxt_pulse;
      state_ff <= nxt_state;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign cfg_q = cfg_ff;
  assign update_q = {5'h00, sync_edge_ff, ack_ff, req_ff};
  assign tw_q = tw_ff;
  assign ctrl.osc_enable = cfg_ff[cntc_pkg::CFG_OSC_EN_BIT];
  assign ctrl.modulus_enable = cfg_ff[cntc_pkg::CFG_MODULUS_BIT];
  assign ctrl.sideband_select = cfg_ff[cntc_pkg::CFG_SIDEBAND_BIT];
  assign ctrl.test_tone_dc_inject = cfg_ff[cntc_pkg::CFG_DC_INJECT_BIT];
  assign ctrl.dc_level = dc_ff;
  assign ctrl.active_tuning_word = active_ff;
  assign ctrl.load_pulse = pulse_ff;

endmodule

// >>> rtl/cntc_pkg.sv
// package of constants and types for the channel tuning control block
package cntc_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_CH = 6;
  localparam int ADDR_W = 12;
  localparam int TW_W = 16;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [11:0] PAGE_ADDR = 12'h008;
  localparam logic [11:0] PATH_CFG_ADDR = 12'h130;
  localparam logic [11:0] TUNING_UPDATE_ADDR = 12'h131;
  localparam logic [11:0] TUNING_WORD_BYTE0_ADDR = 12'h132;
  localparam logic [11:0] TUNING_WORD_BYTE1_ADDR = 12'h133;

  // ****************************************
  // field positions, masks and reset values
  // ****************************************
  localparam int CFG_DC_INJECT_BIT = 0;
  localparam int CFG_SIDEBAND_BIT = 1;
  localparam int CFG_MODULUS_BIT = 2;
  localparam int CFG_OSC_EN_BIT = 6;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h7f;
  localparam int UPD_REQUEST_BIT = 0;
  localparam int UPD_ACK_BIT = 1;
  localparam int UPD_SYNC_EDGE_BIT = 2;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [15:0] TW_RESET = 16'h0000;
  localparam logic [5:0] PAGE_RESET = 6'h01;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [0:0] {
    LOAD_IDLE = 1'b0,
    LOAD_ARMED = 1'b1
  } cntc_load_e;

  typedef struct packed {
    logic osc_enable;
    logic modulus_enable;
    logic sideband_select;
    logic test_tone_dc_inject;
    logic [15:0] dc_level;
    logic [15:0] active_tuning_word;
    logic load_pulse;
  } cntc_ctrl_s;

endpackage

// >>> rtl/cntc_top.sv
// paged register bank for the channel oscillator tuning controls
// ****************************************
// Functional notes
// - path config bit 1 picks the sideband, 0 upper and 1 lower (spectral flip).
// - path config bit 0 sends the test tone level as a constant into the oscillator input.
// - with update bit 2 set the load and oscillator reset wait for the next sync rising edge.
// - update bit 1 is a read-only flag that reads 1 once the tuning word is loaded.
// - a 0 to 1 step of update bit 0 loads the programmed tuning word.
// - tuning word bits 7:0 sit at 0x132 and bits 15:8 at 0x133, both resetting to zero.
// - with modulus off the oscillator runs at sample rate times word over two to the 48.
// - with modulus on the fraction delta over modulus is added to the word.
// - every control exists per channel and the page register at 0x008 picks the copies.
// - path config bit 2 enables fractional modulus operation for the channel.
// ****************************************
`timescale 1ns/1ps
module cntc_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic sysref_in,
  input wire logic [15:0] test_tone_level,
  output cntc_pkg::cntc_ctrl_s [cntc_pkg::NUM_CH-1:0] ch_ctrl
);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic [2:0] first_channel(input logic [5:0] page);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = cntc_pkg::NUM_CH - 1; i >= 0; i--) begin
      if (page[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic is_channel_addr(input logic [11:0] addr);
    return (addr == cntc_pkg::PATH_CFG_ADDR) || (addr == cntc_pkg::TUNING_UPDATE_ADDR) ||
      (addr == cntc_pkg::TUNING_WORD_BYTE0_ADDR) || (addr == cntc_pkg::TUNING_WORD_BYTE1_ADDR);
  endfunction

  // ****************************************
  // sync edge synchroniser
  // ****************************************
  logic sref_meta_ff, sref_sync_ff, sref_prev_ff;
  logic nxt_sref_meta, nxt_sref_sync, nxt_sref_prev;
  logic sync_rise;

  always_comb begin
    nxt_sref_meta = sysref_in;
    nxt_sref_sync = sref_meta_ff;
    nxt_sref_prev = sref_sync_ff;
    sync_rise = sref_sync_ff & ~sref_prev_ff;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sref_meta_ff <= 1'b0;
      sref_sync_ff <= 1'b0;
      sref_prev_ff <= 1'b0;
    end else begin
      sref_meta_ff <= nxt_sref_meta;
      sref_sync_ff <= nxt_sref_sync;
      sref_prev_ff <= nxt_sref_prev;
    end
  end

  // ****************************************
  // channel page register
  // ****************************************
  logic [5:0] page_ff, nxt_page;

  always_comb begin
    nxt_page = page_ff;
    if (reg_wr && (reg_addr == cntc_pkg::PAGE_ADDR)) begin
      nxt_page = reg_wdata[5:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      page_ff <= cntc_pkg::PAGE_RESET;
    end else begin
      page_ff <= nxt_page;
    end
  end

  // ****************************************
  // channel copies
  // ****************************************
  logic [7:0] cfg_q [cntc_pkg::NUM_CH];
  logic [7:0] update_q [cntc_pkg::NUM_CH];
  logic [15:0] tw_q [cntc_pkg::NUM_CH];

  for (genvar g = 0; g < cntc_pkg::NUM_CH; g++) begin : g_ch
    cntc_channel u_ch (
      .core_clk(core_clk),
      .rst(rst),
      .wr_sel(reg_wr & page_ff[g] & is_channel_addr(reg_addr)),
      .wr_addr(reg_addr),
      .wr_data(reg_wdata),
      .sync_rise(sync_rise),
      .test_tone_level(test_tone_level),
      .cfg_q(cfg_q[g]),
      .update_q(update_q[g]),
      .tw_q(tw_q[g]),
      .ctrl(ch_ctrl[g])
    );
  end

  // ****************************************
  // read path
  // ****************************************
  logic [7:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;
  logic [2:0] rd_ch;

  always_comb begin
    // reads come from the lowest selected channel copy
    rd_ch = first_channel(page_ff);
    nxt_rvalid = reg_rd;
    nxt_rdata = rdata_ff;
    if (reg_rd) begin
      case (reg_addr)
        cntc_pkg::PAGE_ADDR: nxt_rdata = {2'b00, page_ff};
        cntc_pkg::PATH_CFG_ADDR: nxt_rdata = cfg_q[rd_ch];
        cntc_pkg::TUNING_UPDATE_ADDR: nxt_rdata = update_q[rd_ch];
        cntc_pkg::TUNING_WORD_BYTE0_ADDR: nxt_rdata = tw_q[rd_ch][7:0];
        cntc_pkg::TUNING_WORD_BYTE1_ADDR: nxt_rdata = tw_q[rd_ch][15:8];
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;

endmodule

// >>> tb/cntc_top_asserts.sv
// port assertions for the channel tuning control block
`timescale 1ns/1ps
module cntc_top_asserts (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire cntc_pkg::cntc_ctrl_s [cntc_pkg::NUM_CH-1:0] ch_ctrl
);
  logic [5:0] page_ff;
  logic req_ff;
  logic cfg_wr;
  logic upd_wr;
  // mirror of the page and of channel 0 request bit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      page_ff <= 6'h01;
      req_ff <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == 12'h008) page_ff <= reg_wdata[5:0];
      if (reg_addr == 12'h131 && page_ff[0]) req_ff <= reg_wdata[0];
    end
  end
  assign cfg_wr = reg_wr && reg_addr == 12'h130 && page_ff[0];
  assign upd_wr = reg_wr && reg_addr == 12'h131 && page_ff[0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_req_rise;
    reg_wr && reg_addr == 12'h131 && page_ff[0] && !req_ff && reg_wdata[0] && !reg_wdata[2];
  endsequence
  sequence s_ack_read;
    s_req_rise ##1 !upd_wr ##1 (reg_rd && reg_addr == 12'h131 && page_ff[0]);
  endsequence
  a_rd_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read valid without read");
  a_sideband_set: assert property (cfg_wr |=> ch_ctrl[0].sideband_select == $past(reg_wdata[1]))
    else $error("sideband not taken");
  a_dc_inject_set: assert property (cfg_wr |=> ch_ctrl[0].test_tone_dc_inject == $past(reg_wdata[0]))
    else $error("dc inject not taken");
  a_modulus_set: assert property (cfg_wr |=> ch_ctrl[0].modulus_enable == $past(reg_wdata[2]))
    else $error("modulus enable not taken");
  a_req_loads: assert property (s_req_rise |=> ch_ctrl[0].load_pulse)
    else $error("request edge did not load");
  a_pulse_single: assert property (ch_ctrl[0].load_pulse && !upd_wr |=> !ch_ctrl[0].load_pulse)
    else $error("load pulse too long");
  a_word_at_load: assert property ($changed(ch_ctrl[0].active_tuning_word) |-> ch_ctrl[0].load_pulse)
    else $error("word changed without load");
  a_ack_after_load: assert property (s_ack_read |=> reg_rdata[1])
    else $error("ack not set after load");
endmodule
bind cntc_top cntc_top_asserts u_chk (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .ch_ctrl(ch_ctrl));

// >>> tb/cntc_host.sv
// host model driving the register port and the sync input
`timescale 1ns/1ps
module cntc_host (
  input wire logic core_clk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic [11:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  output logic sysref_in
);
  initial begin
    reg_addr = 12'h000;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    sysref_in = 1'b0;
  end
  // one write strobe; data scrambled once released
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_wdata = ~v;
  endtask
  // read answer comes one cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [7:0] v, output logic ok);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    ok = (reg_rvalid === 1'b1);
    v = reg_rdata;
  endtask
  task automatic sync_level(input logic v);
    @(negedge core_clk);
    sysref_in = v;
  endtask
endmodule

// >>> tb/tb.sv
// self-checking bench for the channel tuning control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); \
  end \
end
module tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] reg_addr;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic sysref_in;
  logic [15:0] test_tone_level = 16'h1234;
  cntc_pkg::cntc_ctrl_s [cntc_pkg::NUM_CH-1:0] ch_ctrl;
  int failures = 0;
  int num_checks = 0;
  logic [7:0] d;
  logic ok;
  always #4 core_clk = ~core_clk;
  cntc_top DUT (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .sysref_in(sysref_in), .test_tone_level(test_tone_level), .ch_ctrl(ch_ctrl));
  cntc_host host (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .sysref_in(sysref_in));
  // ****
  // shared tasks
  // ****
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    host.rd(a, d, ok);
    `CHK("rvalid", 1'b1, ok)
    `CHK("rdata", e, d)
  endtask
  // pulse may already stand when the write task returns
  task automatic wpulse(input int lim);
    ok = 1'b0;
    for (int n = 0; n < lim && !ok; n++) begin
      ok = (ch_ctrl[0].load_pulse === 1'b1);
      if (!ok) @(negedge core_clk);
    end
    if (!ok) begin
      failures++;
      $display("mismatch load_pulse expected 1 seen 0");
      stop_test();
    end
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset();
    rchk(12'h008, 8'h01);
    rchk(12'h130, 8'h00);
    rchk(12'h131, 8'h00);
    rchk(12'h132, 8'h00);
    rchk(12'h133, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_cfg();
    host.wr(12'h130, 8'h47);
    rchk(12'h130, 8'h47);
    `CHK("sideband", 1'b1, ch_ctrl[0].sideband_select)
    `CHK("modulus", 1'b1, ch_ctrl[0].modulus_enable)
    `CHK("osc_en", 1'b1, ch_ctrl[0].osc_enable)
    `CHK("dc_level", 16'h1234, ch_ctrl[0].dc_level)
    `CHK("other_ch", 1'b0, ch_ctrl[1].sideband_select)
    host.wr(12'h130, 8'hff);
    rchk(12'h130, 8'h7f);
    host.wr(12'h130, 8'h00);
    rchk(12'h130, 8'h00);
    `CHK("dc_off", 16'h0000, ch_ctrl[0].dc_level)
    $display("test cfg done");
  endtask
  task automatic t_load();
    host.wr(12'h132, 8'ha5);
    host.wr(12'h133, 8'h5a);
    rchk(12'h133, 8'h5a);
    `CHK("word_hold", 16'h0000, ch_ctrl[0].active_tuning_word)
    host.wr(12'h131, 8'h01);
    wpulse(2);
    `CHK("word_load", 16'h5aa5, ch_ctrl[0].active_tuning_word)
    rchk(12'h131, 8'h03);
    host.wr(12'h132, 8'h3c);
    host.wr(12'h131, 8'h01);
    `CHK("no_reload", 16'h5aa5, ch_ctrl[0].active_tuning_word)
    host.wr(12'h131, 8'h00);
    rchk(12'h131, 8'h02);
    $display("test load done");
  endtask
  task automatic t_sync();
    host.wr(12'h131, 8'h04);
    rchk(12'h131, 8'h04);
    repeat (4) @(negedge core_clk);
    `CHK("word_armed", 16'h5aa5, ch_ctrl[0].active_tuning_word)
    host.sync_level(1'b1);
    wpulse(6);
    `CHK("word_sync", 16'h5a3c, ch_ctrl[0].active_tuning_word)
    host.sync_level(1'b0);
    rchk(12'h131, 8'h06);
    $display("test sync done");
  endtask
  task automatic t_rearm();
    host.wr(12'h131, 8'h05);
    rchk(12'h131, 8'h05);
    host.wr(12'h133, 8'hc3);
    host.wr(12'h131, 8'h00);
    rchk(12'h131, 8'h00);
    `CHK("word_cancel", 16'h5a3c, ch_ctrl[0].active_tuning_word)
    host.wr(12'h131, 8'h04);
    host.wr(12'h131, 8'h01);
    wpulse(2);
    `CHK("word_direct", 16'hc33c, ch_ctrl[0].active_tuning_word)
    rchk(12'h131, 8'h03);
    $display("test rearm done");
  endtask
  task automatic t_page();
    host.wr(12'h008, 8'h02);
    rchk(12'h008, 8'h02);
    host.wr(12'h132, 8'h77);
    rchk(12'h132, 8'h77);
    host.wr(12'h008, 8'h01);
    rchk(12'h132, 8'h3c);
    rchk(12'h200, 8'h00);
    $display("test page done");
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    t_reset();
    t_cfg();
    t_load();
    t_sync();
    t_rearm();
    t_page();
    stop_test();
  end
endmodule
